// ==== core/vga_dac_pixel_port.sv ====
// Pixel port driving a triple video DAC and the display sync lines
`timescale 1ns/1ns
`default_nettype none
// How it works
// - A full 30-bit colour word of three 10-bit parts is registered out on every clock inside the visible area; black is registered outside it.
// - Each colour part has its own bus with bit 0 as lsb up to bit 9 as msb.
// - Line and frame sync are made here and driven straight to the display.
// - The blanking strobe is low outside the visible area and high inside it.
// - Line sync is low only during the line sync pulse.
// - Frame sync is low only during the frame sync pulse.
module vga_dac_pixel_port (
	input  wire logic             i_clk_sys,
	input  wire logic             i_rst,
	input  wire vga_dac_pkg::timing_s i_h_timing,
	input  wire vga_dac_pkg::timing_s i_v_timing,
	input  wire vga_dac_pkg::pixel_s  i_pixel,
	output logic                  o_pixel_clock_out,
	output vga_dac_pkg::pixel_s   o_pixel,
	output vga_dac_pkg::comp_t    o_red_code_bit,
	output vga_dac_pkg::comp_t    o_green_code_bit,
	output vga_dac_pkg::comp_t    o_blue_code_bit,
	output logic                  o_blank_n,
	output logic                  o_line_sync_n,
	output logic                  o_frame_sync_n,
	output logic                  o_pixel_req,
	output vga_dac_pkg::count_t   o_h_pos,
	output vga_dac_pkg::count_t   o_v_pos
);
	import vga_dac_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	function automatic count_t seg_total(input timing_s t);
		seg_total = t.visible + t.front + t.sync + t.back;
	endfunction

	function automatic logic in_sync(input count_t c, input timing_s t);
		in_sync = (c >= count_t'(t.visible + t.front)) &&
			(c < count_t'(t.visible + t.front + t.sync));
	endfunction

	////////////////////////////////////////////////////////////////////////////
	count_t h_reg;
	count_t h_next;
	count_t v_reg;
	count_t v_next;
	pixel_s pix_reg;
	logic   blank_n_reg;
	logic   hs_n_reg;
	logic   vs_n_reg;

	wire logic h_last  = (h_reg >= count_t'(seg_total(i_h_timing) - CNT_ONE));
	wire logic v_last  = (v_reg >= count_t'(seg_total(i_v_timing) - CNT_ONE));
	wire logic visible = (h_reg < i_h_timing.visible) && (v_reg < i_v_timing.visible);
	wire logic hs_now  = in_sync(h_reg, i_h_timing);
	wire logic vs_now  = in_sync(v_reg, i_v_timing);

	assign h_next = h_last ? CNT_ZERO : count_t'(h_reg + CNT_ONE);
	assign v_next = h_last ? (v_last ? CNT_ZERO : count_t'(v_reg + CNT_ONE)) : v_reg;

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			h_reg <= CNT_ZERO;
			v_reg <= CNT_ZERO;
		end else begin
			h_reg <= h_next;
			v_reg <= v_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// colour word register
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			pix_reg <= '0;
		end else if (visible) begin
			pix_reg <= i_pixel;
		end else begin
			pix_reg <= '{red: COMP_ZERO, green: COMP_ZERO, blue: COMP_ZERO};
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			blank_n_reg <= 1'b0;
			hs_n_reg    <= 1'b1;
			vs_n_reg    <= 1'b1;
		end else begin
			blank_n_reg <= visible;
			hs_n_reg    <= ~hs_now;
			vs_n_reg    <= ~vs_now;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// separate component buses
	assign o_red_code_bit    = pix_reg.red;
	assign o_green_code_bit  = pix_reg.green;
	assign o_blue_code_bit   = pix_reg.blue;
	assign o_pixel           = pix_reg;
	assign o_pixel_clock_out = i_clk_sys;
	assign o_blank_n         = blank_n_reg;
	assign o_line_sync_n     = hs_n_reg;
	assign o_frame_sync_n    = vs_n_reg;
	assign o_pixel_req       = visible && !i_rst;
	assign o_h_pos           = h_reg;
	assign o_v_pos           = v_reg;

	////////////////////////////////////////////////////////////////////////////
	property p_blank_visible;
		@(posedge i_clk_sys) disable iff (i_rst)
		1'b1 |=> (o_blank_n == $past(visible));
	endproperty
	a_blank_visible: assert property (p_blank_visible) else $error("blank wrong");

	property p_hsync;
		@(posedge i_clk_sys) disable iff (i_rst)
		1'b1 |=> (o_line_sync_n == !$past(hs_now));
	endproperty
	a_hsync: assert property (p_hsync) else $error("line sync wrong");

	property p_vsync;
		@(posedge i_clk_sys) disable iff (i_rst)
		1'b1 |=> (o_frame_sync_n == !$past(vs_now));
	endproperty
	a_vsync: assert property (p_vsync) else $error("frame sync wrong");

	property p_pixel;
		@(posedge i_clk_sys) disable iff (i_rst)
		visible |=> (o_pixel == $past(i_pixel));
	endproperty
	a_pixel: assert property (p_pixel) else $error("pixel not passed");

	property p_black;
		@(posedge i_clk_sys) disable iff (i_rst)
		!o_blank_n |-> (o_pixel == '0);
	endproperty
	a_black: assert property (p_black) else $error("colour in blank");

	property p_hwrap;
		@(posedge i_clk_sys) disable iff (i_rst)
		h_last |=> (h_reg == CNT_ZERO);
	endproperty
	a_hwrap: assert property (p_hwrap) else $error("pixel counter wrap");

	property p_hstep;
		@(posedge i_clk_sys) disable iff (i_rst)
		!h_last |=> (h_reg == count_t'($past(h_reg) + CNT_ONE)) && $stable(v_reg);
	endproperty
	a_hstep: assert property (p_hstep) else $error("pixel counter step");

	property p_sync_blank;
		@(posedge i_clk_sys) disable iff (i_rst)
		!o_line_sync_n |-> !o_blank_n;
	endproperty
	a_sync_blank: assert property (p_sync_blank) else $error("sync in visible");

	property p_vwrap;
		@(posedge i_clk_sys) disable iff (i_rst)
		h_last && v_last |=> (v_reg == CNT_ZERO);
	endproperty
	a_vwrap: assert property (p_vwrap) else $error("line counter wrap");

	property p_vstep;
		@(posedge i_clk_sys) disable iff (i_rst)
		h_last && !v_last |=> (v_reg == count_t'($past(v_reg) + CNT_ONE));
	endproperty
	a_vstep: assert property (p_vstep) else $error("line counter step");

	property p_red_bus;
		@(posedge i_clk_sys) disable iff (i_rst)
		visible |=> (o_red_code_bit == $past(i_pixel.red));
	endproperty
	a_red_bus: assert property (p_red_bus) else $error("red bus order");

	property p_green_bus;
		@(posedge i_clk_sys) disable iff (i_rst)
		visible |=> (o_green_code_bit == $past(i_pixel.green));
	endproperty
	a_green_bus: assert property (p_green_bus) else $error("green bus order");

	property p_blue_bus;
		@(posedge i_clk_sys) disable iff (i_rst)
		visible |=> (o_blue_code_bit == $past(i_pixel.blue));
	endproperty
	a_blue_bus: assert property (p_blue_bus) else $error("blue bus order");

	property p_req_blank;
		@(posedge i_clk_sys) disable iff (i_rst)
		o_pixel_req |=> o_blank_n;
	endproperty
	a_req_blank: assert property (p_req_blank) else $error("blank on requested pixel");

	property p_hs_fall;
		@(posedge i_clk_sys) disable iff (i_rst)
		$fell(o_line_sync_n) |->
			($past(o_h_pos) == count_t'(i_h_timing.visible + i_h_timing.front));
	endproperty
	a_hs_fall: assert property (p_hs_fall) else $error("line sync start");

	////////////////////////////////////////////////////////////////////////////
	// sync low length
	count_t hs_low_reg;

	always_ff @(posedge i_clk_sys) begin
		if (i_rst || o_line_sync_n) begin
			hs_low_reg <= CNT_ZERO;
		end else begin
			hs_low_reg <= count_t'(hs_low_reg + CNT_ONE);
		end
	end

	property p_hs_len;
		@(posedge i_clk_sys) disable iff (i_rst)
		$rose(o_line_sync_n) |-> (hs_low_reg == i_h_timing.sync);
	endproperty
	a_hs_len: assert property (p_hs_len) else $error("line sync length");

	property p_frame_steady;
		@(posedge i_clk_sys) disable iff (i_rst)
		(o_h_pos != CNT_ONE) |-> $stable(o_frame_sync_n);
	endproperty
	a_frame_steady: assert property (p_frame_steady) else $error("frame sync mid line");

	property p_vs_fall;
		@(posedge i_clk_sys) disable iff (i_rst)
		$fell(o_frame_sync_n) |->
			($past(o_v_pos) == count_t'(i_v_timing.visible + i_v_timing.front));
	endproperty
	a_vs_fall: assert property (p_vs_fall) else $error("frame sync start");
endmodule
`default_nettype wire

// ==== shared/vga_dac_pkg.sv ====
// Timing constants and pixel carrier types for the video DAC pixel port
`default_nettype none
package vga_dac_pkg;
	localparam int COMP_W = 10;
	localparam int CNT_W  = 11;
	typedef logic [CNT_W-1:0] count_t;
	typedef logic [COMP_W-1:0] comp_t;

	// Colour word: red, green, blue, each bit 0 = lsb
	typedef struct packed {
		comp_t red;
		comp_t green;
		comp_t blue;
	} pixel_s;

	// Line or frame timing segment lengths
	typedef struct packed {
		count_t visible;
		count_t front;
		count_t sync;
		count_t back;
	} timing_s;

	localparam count_t H_VISIBLE = 11'h280;
	localparam count_t H_FRONT   = 11'h010;
	localparam count_t H_SYNC    = 11'h060;
	localparam count_t H_BACK    = 11'h030;
	localparam count_t V_VISIBLE = 11'h1e0;
	localparam count_t V_FRONT   = 11'h00a;
	localparam count_t V_SYNC    = 11'h002;
	localparam count_t V_BACK    = 11'h021;
	localparam count_t CNT_ZERO  = 11'h000;
	localparam count_t CNT_ONE   = 11'h001;
	localparam comp_t  COMP_ZERO = 10'h000;
endpackage
`default_nettype wire

// ==== tb/dac_model.sv ====
// Video DAC stand-in latching each colour word
`timescale 1ns/1ns
`default_nettype none
module dac_model (
	input  wire logic               i_clk,
	input  wire vga_dac_pkg::comp_t i_r,
	input  wire vga_dac_pkg::comp_t i_g,
	input  wire vga_dac_pkg::comp_t i_b,
	input  wire logic               i_blank_n,
	output logic [29:0]             o_seen
);
	// Blanked words come out black
	always_ff @(posedge i_clk) o_seen <= i_blank_n ? {i_r, i_g, i_b} : 30'h0;
endmodule
`default_nettype wire

// ==== tb/vga_dac_pixel_port_bench.sv ====
// Self-checking bench for the pixel port
`timescale 1ns/1ns
`default_nettype none
module vga_dac_pixel_port_bench;
	import vga_dac_pkg::*;
	logic        clk = 0;
	logic        rst = 1;
	timing_s     th = '0;
	timing_s     tv = '0;
	pixel_s      px = '0;
	pixel_s      o_px;
	comp_t       r, g, b;
	logic        pclk, bl, ls, fs, req;
	count_t      hp, vp, h, v;
	logic [29:0] seen, pw;
	logic [32:0] e;
	int          n_mismatch = 0;
	int          comparisons = 0;
	initial forever #20 clk = ~clk;
	vga_dac_pixel_port i_vga_dac_pixel_port (.i_clk_sys(clk), .i_rst(rst), .i_h_timing(th),
		.i_v_timing(tv), .i_pixel(px), .o_pixel_clock_out(pclk), .o_pixel(o_px),
		.o_red_code_bit(r), .o_green_code_bit(g), .o_blue_code_bit(b), .o_blank_n(bl),
		.o_line_sync_n(ls), .o_frame_sync_n(fs), .o_pixel_req(req), .o_h_pos(hp),
		.o_v_pos(vp));
	dac_model i_dac_model (.i_clk(pclk), .i_r(r), .i_g(g), .i_b(b), .i_blank_n(bl),
		.o_seen(seen));
	function automatic logic in_seg(count_t p, count_t lo, count_t n);
		return p >= lo && p < lo + n;
	endfunction
	function automatic count_t tot(timing_s t);
		return t.visible + t.front + t.sync + t.back;
	endfunction
	function automatic logic [32:0] expect_out(count_t x, count_t y, pixel_s p);
		logic vis;
		vis = in_seg(x, 11'h0, th.visible) && in_seg(y, 11'h0, tv.visible);
		return {vis ? 30'(p) : 30'h0, vis, !in_seg(x, th.visible + th.front, th.sync),
			!in_seg(y, tv.visible + tv.front, tv.sync)};
	endfunction
	task automatic chk(string nm, logic [32:0] x, logic [32:0] y);
		comparisons++;
		if (x !== y) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, x, y);
		end
	endtask
	task automatic tally_and_finish();
		$display("Counts: %0d mismatches, %0d comparisons", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Reset, then a random pixel stream checked every cycle
	task automatic run(timing_s a, timing_s c, int n);
		rst = 1;
		th = a;
		tv = c;
		h = CNT_ZERO;
		v = CNT_ZERO;
		pw = 30'h0;
		repeat (20) @(negedge clk);
		rst = 0;
		px = pixel_s'(30'($urandom));
		e = expect_out(h, v, px);
		repeat (n) begin
			@(negedge clk);
			chk("word", e, {o_px, bl, ls, fs});
			chk("buses", e, {r, g, b, bl, ls, fs});
			chk("dac", 33'(pw), 33'(seen));
			pw = e[32:3];
			h = (h + 1 == tot(th)) ? CNT_ZERO : count_t'(h + 1);
			if (h == CNT_ZERO)
				v = (v + 1 == tot(tv)) ? CNT_ZERO : count_t'(v + 1);
			px = pixel_s'(30'($urandom));
			e = expect_out(h, v, px);
			chk("pos", 33'({h, v, e[2], 1'b0}), 33'({hp, vp, req, pclk}));
		end
		$display("Test done: %0d cycles", n);
	endtask
	initial begin
		void'($urandom(58));
		run('{11'h8, 11'h2, 11'h3, 11'h2}, '{11'h4, 11'h1, 11'h2, 11'h1}, 300);
		run('{11'h5, 11'h1, 11'h1, 11'h1}, '{11'h2, 11'h1, 11'h1, 11'h1}, 100);
		run('{H_VISIBLE, H_FRONT, H_SYNC, H_BACK}, '{V_VISIBLE, V_FRONT, V_SYNC, V_BACK}, 2000);
		tally_and_finish();
	end
endmodule
`default_nettype wire
